// File: core/arfr_top.sv
`timescale 1ns/1ps
// How it works
// - With request error code E506 stored, the three request detail words carry detail codes 1 to 3.
// - With any other request error code, the three request detail words read FFFF.
// - The alarm 1 error code word is written only when alarm 1's acknowledge failed.
// - With alarm 1 error code E508 stored, the alarm 1 detail words carry its detail codes 1 to 3.
// - With any other alarm 1 error code, the alarm 1 detail words read FFFF.
// - The request error code of a failed alarm read sits in word 26446 and selects the request detail words.
// - Per-alarm error data is written only when that alarm's acknowledge bit in word 26448 is clear.
module arfr_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [arfr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [arfr_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [arfr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [arfr_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fail_evt,
	input wire logic [arfr_pkg::WORD_W-1:0] req_err_code,
	input wire logic [arfr_pkg::WORD_W-1:0] ack_status,
	input wire arfr_pkg::arfr_det_t req_detail,
	input wire logic [arfr_pkg::WORD_W-1:0] alarm1_err_code,
	input wire arfr_pkg::arfr_det_t alarm1_detail,
	output logic resp_valid,
	output logic resp_overrun
);
	import arfr_pkg::*;

	arfr_reg_if rif ();

	logic [WORD_W-1:0] req_err_ff;
	logic [WORD_W-1:0] ack_stat_ff;
	arfr_det_t req_det_ff;
	logic [WORD_W-1:0] al1_err_ff;
	arfr_det_t al1_det_ff;
	logic resp_valid_ff;
	logic overrun_ff;
	logic cap_en_ff;
	arfr_det_t nxt_req_det;
	arfr_det_t nxt_al1_det;
	logic capture;
	logic al1_failed;
	logic ctrl_wr;
	logic clr_valid;
	logic clr_ovr;
	logic unused_prot;

	assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

	arfr_axil_slave u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rif(rif.bus)
	);

	arfr_detail_sel #(.TRIGGER(CODE_REQ_DETAIL)) u_req_sel (
		.err_code(req_err_code),
		.det_in(req_detail),
		.det_out(nxt_req_det)
	);

	arfr_detail_sel #(.TRIGGER(CODE_AL_DETAIL)) u_al1_sel (
		.err_code(alarm1_err_code),
		.det_in(alarm1_detail),
		.det_out(nxt_al1_det)
	);

	assign capture = fail_evt && cap_en_ff;
	assign al1_failed = !ack_status[ACK_AL1_BIT];
	assign ctrl_wr = rif.wr_en && (rif.wr_idx == IDX_CTRL) && rif.wr_strb[0];
	assign clr_valid = ctrl_wr && rif.wr_data[CTRL_CLR_VALID_BIT];
	assign clr_ovr = ctrl_wr && rif.wr_data[CTRL_CLR_OVR_BIT];

	// Request-level words: error code and its detail words land on the same edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_err_ff <= RST_ERR;
			ack_stat_ff <= RST_ACK;
			req_det_ff <= {DET_N{RST_DET}};
		end else if (capture) begin
			req_err_ff <= req_err_code;
			ack_stat_ff <= ack_status;
			req_det_ff <= nxt_req_det;
		end
	end

	// Alarm 1 words are left untouched when its acknowledge completed normally
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			al1_err_ff <= RST_ERR;
			al1_det_ff <= {DET_N{RST_DET}};
		end else if (capture && al1_failed) begin
			al1_err_ff <= alarm1_err_code;
			al1_det_ff <= nxt_al1_det;
		end
	end

	// Response flag rises on the capture edge; a new capture beats a software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			resp_valid_ff <= 1'b0;
		end else if (capture) begin
			resp_valid_ff <= 1'b1;
		end else if (clr_valid) begin
			resp_valid_ff <= 1'b0;
		end
	end

	// Overrun marks a capture that replaced a response not yet cleared
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overrun_ff <= 1'b0;
		end else if (capture && resp_valid_ff && !clr_valid) begin
			overrun_ff <= 1'b1;
		end else if (clr_ovr) begin
			overrun_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_en_ff <= RST_CAP_EN;
		end else if (ctrl_wr) begin
			cap_en_ff <= rif.wr_data[CTRL_CAP_EN_BIT];
		end
	end

	assign resp_valid = resp_valid_ff;
	assign resp_overrun = overrun_ff;

	// Writes are accepted only at the control word; read-only words answer and ignore data
	always_comb begin
		rif.wr_ok = 1'b0;
		if ((rif.wr_idx == IDX_REQ_ERR) || (rif.wr_idx == IDX_ACK_STAT) || (rif.wr_idx == IDX_CTRL) ||
			(rif.wr_idx == IDX_STATUS) || ((rif.wr_idx >= IDX_REQ_DET1) && (rif.wr_idx <= IDX_AL1_DET3))) begin
			rif.wr_ok = 1'b1;
		end
	end

	// Read decode; 16-bit words sit in the low half, upper bits read zero
	always_comb begin
		rif.rd_data = '0;
		rif.rd_ok = 1'b1;
		if (rif.rd_idx == IDX_REQ_ERR) begin
			rif.rd_data[WORD_W-1:0] = req_err_ff;
		end else if (rif.rd_idx == IDX_ACK_STAT) begin
			rif.rd_data[WORD_W-1:0] = ack_stat_ff;
		end else if (rif.rd_idx == IDX_REQ_DET1) begin
			rif.rd_data[WORD_W-1:0] = req_det_ff[0];
		end else if (rif.rd_idx == IDX_REQ_DET2) begin
			rif.rd_data[WORD_W-1:0] = req_det_ff[1];
		end else if (rif.rd_idx == IDX_REQ_DET3) begin
			rif.rd_data[WORD_W-1:0] = req_det_ff[2];
		end else if ((rif.rd_idx >= IDX_GAP_FIRST) && (rif.rd_idx <= IDX_GAP_LAST)) begin
			rif.rd_data[WORD_W-1:0] = GAP_VALUE;
		end else if (rif.rd_idx == IDX_AL1_ERR) begin
			rif.rd_data[WORD_W-1:0] = al1_err_ff;
		end else if (rif.rd_idx == IDX_AL1_DET1) begin
			rif.rd_data[WORD_W-1:0] = al1_det_ff[0];
		end else if (rif.rd_idx == IDX_AL1_DET2) begin
			rif.rd_data[WORD_W-1:0] = al1_det_ff[1];
		end else if (rif.rd_idx == IDX_AL1_DET3) begin
			rif.rd_data[WORD_W-1:0] = al1_det_ff[2];
		end else if (rif.rd_idx == IDX_CTRL) begin
			rif.rd_data[CTRL_CAP_EN_BIT] = cap_en_ff;
		end else if (rif.rd_idx == IDX_STATUS) begin
			rif.rd_data[STAT_VALID_BIT] = resp_valid_ff;
			rif.rd_data[STAT_OVR_BIT] = overrun_ff;
		end else begin
			rif.rd_ok = 1'b0;
		end
	end
endmodule

// File: core/arfr_pkg.sv
package arfr_pkg;
	localparam int ADDR_W = 17;
	localparam int IDX_W = 15;
	localparam int DATA_W = 32;
	localparam int WORD_W = 16;
	localparam int DET_N = 3;

	// Word indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_REQ_ERR = 15'h674E;
	localparam logic [IDX_W-1:0] IDX_ACK_STAT = 15'h6750;
	localparam logic [IDX_W-1:0] IDX_REQ_DET1 = 15'h6751;
	localparam logic [IDX_W-1:0] IDX_REQ_DET2 = 15'h6752;
	localparam logic [IDX_W-1:0] IDX_REQ_DET3 = 15'h6753;
	localparam logic [IDX_W-1:0] IDX_GAP_FIRST = 15'h6754;
	localparam logic [IDX_W-1:0] IDX_GAP_LAST = 15'h6774;
	localparam logic [IDX_W-1:0] IDX_AL1_ERR = 15'h6775;
	localparam logic [IDX_W-1:0] IDX_AL1_DET1 = 15'h6776;
	localparam logic [IDX_W-1:0] IDX_AL1_DET2 = 15'h6777;
	localparam logic [IDX_W-1:0] IDX_AL1_DET3 = 15'h6778;
	localparam logic [IDX_W-1:0] IDX_CTRL = 15'h6900;
	localparam logic [IDX_W-1:0] IDX_STATUS = 15'h6901;

	localparam logic [WORD_W-1:0] CODE_REQ_DETAIL = 16'hE506;
	localparam logic [WORD_W-1:0] CODE_AL_DETAIL = 16'hE508;
	localparam logic [WORD_W-1:0] NO_DETAIL = 16'hFFFF;
	localparam logic [WORD_W-1:0] GAP_VALUE = 16'h0000;

	localparam logic [WORD_W-1:0] RST_ERR = 16'h0000;
	localparam logic [WORD_W-1:0] RST_DET = 16'hFFFF;
	localparam logic [WORD_W-1:0] RST_ACK = 16'h0000;
	localparam logic RST_CAP_EN = 1'b1;

	localparam int ACK_AL1_BIT = 8;
	localparam int CTRL_CLR_VALID_BIT = 0;
	localparam int CTRL_CLR_OVR_BIT = 1;
	localparam int CTRL_CAP_EN_BIT = 2;
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_OVR_BIT = 1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef logic [DET_N-1:0][WORD_W-1:0] arfr_det_t;
endpackage

// File: core/arfr_reg_if.sv
`timescale 1ns/1ps
interface arfr_reg_if;
	logic wr_en;
	logic [arfr_pkg::IDX_W-1:0] wr_idx;
	logic [arfr_pkg::DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic rd_en;
	logic [arfr_pkg::IDX_W-1:0] rd_idx;
	logic [arfr_pkg::DATA_W-1:0] rd_data;
	logic rd_ok;

	modport bus (output wr_en, output wr_idx, output wr_data, output wr_strb, input wr_ok,
		output rd_en, output rd_idx, input rd_data, input rd_ok);
	modport regs (input wr_en, input wr_idx, input wr_data, input wr_strb, output wr_ok,
		input rd_en, input rd_idx, output rd_data, output rd_ok);
endinterface

// File: core/arfr_detail_sel.sv
`timescale 1ns/1ps
module arfr_detail_sel #(
	parameter logic [arfr_pkg::WORD_W-1:0] TRIGGER = 16'h0000
) (
	input wire logic [arfr_pkg::WORD_W-1:0] err_code,
	input wire arfr_pkg::arfr_det_t det_in,
	output arfr_pkg::arfr_det_t det_out
);
	import arfr_pkg::*;

	// Detail words pass only for the trigger code, otherwise all read as no-detail
	assign det_out = (err_code == TRIGGER) ? det_in : {DET_N{NO_DETAIL}};
endmodule

// File: core/arfr_axil_slave.sv
`timescale 1ns/1ps
module arfr_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [arfr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [arfr_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [arfr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [arfr_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	arfr_reg_if.bus rif
);
	import arfr_pkg::*;

	logic aw_held_ff;
	logic w_held_ff;
	logic [IDX_W-1:0] aw_idx_ff;
	logic [DATA_W-1:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic wr_fire;
	logic ar_fire;

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign ar_fire = s_axi_arvalid && s_axi_arready;

	assign rif.wr_en = wr_fire;
	assign rif.wr_idx = aw_idx_ff;
	assign rif.wr_data = wdata_ff;
	assign rif.wr_strb = wstrb_ff;
	assign rif.rd_en = ar_fire;
	assign rif.rd_idx = s_axi_araddr[ADDR_W-1:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			aw_idx_ff <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_ff <= 1'b1;
			aw_idx_ff <= s_axi_awaddr[ADDR_W-1:2];
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff <= 1'b0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read data is sampled in the accepting cycle, so one response never mixes two captures
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= '0;
		end else if (ar_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
			rdata_ff <= rif.rd_data;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
endmodule

// File: verif/arfr_top_monitor.sv
`timescale 1ns/1ps
module arfr_top_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [16:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fail_evt,
	input wire logic resp_valid,
	input wire logic resp_overrun
);
	import arfr_pkg::*;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_bus_block: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
		else $error("ready while answer pending");
	a_gap_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[16:2] inside {[IDX_GAP_FIRST:IDX_GAP_LAST]}
		|=> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == RESP_OKAY) else $error("gap word not zero");
	a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[16:2] == 15'h6700
		|=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read not refused");
	a_valid_cause: assert property ($rose(resp_valid) |-> $past(fail_evt))
		else $error("response flag without capture");
	a_ovr_cause: assert property ($rose(resp_overrun) |-> $past(fail_evt) && $past(resp_valid))
		else $error("overrun without second capture");
endmodule
bind arfr_top arfr_top_monitor arfr_top_monitor_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .fail_evt, .resp_valid, .resp_overrun);

// File: verif/arfr_host_model.sv
`timescale 1ns/1ps
module arfr_host_model (
	input wire logic aclk,
	output logic [16:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [16:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	// Handshakes are judged at the falling edge, then acted on at the next rising edge
	task automatic wr(input logic [14:0] i, input logic [31:0] d, output logic [1:0] r);
		logic a;
		logic w;
		logic b;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			a = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
	endtask
	// A slow read holds rready low for one cycle after the address is taken
	task automatic rd(input logic [14:0] i, input logic slow, output logic [31:0] d, output logic [1:0] r);
		logic t;
		@(posedge aclk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			t = s_axi_arready;
			@(posedge aclk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		if (slow) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end while (!t);
		s_axi_rready <= 1'b0;
	endtask
endmodule

// File: verif/arfr_top_tb_top.sv
`timescale 1ns/1ps
module arfr_top_tb_top;
	import arfr_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fail_evt, resp_valid, resp_overrun;
	logic [16:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] req_err_code, ack_status, alarm1_err_code;
	arfr_det_t req_detail, alarm1_detail;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	arfr_top arfr_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .fail_evt, .req_err_code, .ack_status, .req_detail, .alarm1_err_code,
		.alarm1_detail, .resp_valid, .resp_overrun);
	arfr_host_model arfr_host_model_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	task automatic tally_and_finish;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input logic [14:0] i, input logic [15:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		arfr_host_model_i.rd(i, i[0], d, r);
		chk($sformatf("word %h", i), {16'h0000, e}, d);
		chk($sformatf("rresp %h", i), {30'h0, er}, {30'h0, r});
	endtask
	task automatic wrc(input logic [14:0] i, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		arfr_host_model_i.wr(i, d, r);
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic cap(input logic [15:0] rc, input logic [15:0] ak, input arfr_det_t rd, input logic [15:0] ac,
		input arfr_det_t ad);
		@(posedge aclk);
		fail_evt <= 1'b1;
		req_err_code <= rc;
		ack_status <= ak;
		req_detail <= rd;
		alarm1_err_code <= ac;
		alarm1_detail <= ad;
		@(posedge aclk);
		fail_evt <= 1'b0;
		@(negedge aclk);
	endtask
	task automatic t_detail_stored;
		cap(16'hE506, 16'h00FE, {16'h0C03, 16'h0B02, 16'h0A01}, 16'hE508, {16'h1C03, 16'h1B02, 16'h1A01});
		chk("resp_valid", 32'h1, {31'h0, resp_valid});
		chk("resp_overrun", 32'h0, {31'h0, resp_overrun});
		rdc(IDX_REQ_ERR, 16'hE506, RESP_OKAY);
		rdc(IDX_ACK_STAT, 16'h00FE, RESP_OKAY);
		rdc(IDX_AL1_ERR, 16'hE508, RESP_OKAY);
		for (int k = 0; k < 3; k++) begin
			rdc(IDX_REQ_DET1 + 15'(k), 16'h0A01 + 16'(k * 257), RESP_OKAY);
			rdc(IDX_AL1_DET1 + 15'(k), 16'h1A01 + 16'(k * 257), RESP_OKAY);
		end
	endtask
	task automatic t_no_detail;
		cap(16'hE507, 16'h0000, {3{16'h1234}}, 16'hE509, {3{16'h5678}});
		chk("resp_overrun", 32'h1, {31'h0, resp_overrun});
		rdc(IDX_STATUS, 16'h0003, RESP_OKAY);
		rdc(IDX_AL1_ERR, 16'hE509, RESP_OKAY);
		for (int k = 0; k < 3; k++) begin
			rdc(IDX_REQ_DET1 + 15'(k), NO_DETAIL, RESP_OKAY);
			rdc(IDX_AL1_DET1 + 15'(k), NO_DETAIL, RESP_OKAY);
		end
		wrc(IDX_CTRL, 32'h0000_0007, RESP_OKAY);
		rdc(IDX_STATUS, 16'h0000, RESP_OKAY);
	endtask
	task automatic t_ack_done;
		cap(16'hE506, 16'h0100, {3{16'h2222}}, 16'hE508, {3{16'h3333}});
		rdc(IDX_AL1_ERR, 16'hE509, RESP_OKAY);
		rdc(IDX_AL1_DET2, NO_DETAIL, RESP_OKAY);
		rdc(IDX_REQ_DET3, 16'h2222, RESP_OKAY);
	endtask
	task automatic t_gap_and_map;
		rdc(IDX_GAP_FIRST, GAP_VALUE, RESP_OKAY);
		wrc(IDX_GAP_LAST, 32'h0000_BEEF, RESP_OKAY);
		rdc(IDX_GAP_LAST, GAP_VALUE, RESP_OKAY);
		wrc(IDX_REQ_DET1, 32'h0000_5555, RESP_OKAY);
		rdc(IDX_REQ_DET1, 16'h2222, RESP_OKAY);
		rdc(15'h6700, 16'h0000, RESP_SLVERR);
		wrc(15'h6700, 32'h0000_0001, RESP_SLVERR);
		wrc(IDX_CTRL, 32'h0000_0000, RESP_OKAY);
		cap(16'hE506, 16'h0000, {3{16'h4444}}, 16'hE508, {3{16'h4444}});
		rdc(IDX_STATUS, 16'h0001, RESP_OKAY);
		rdc(IDX_REQ_DET2, 16'h2222, RESP_OKAY);
		wrc(IDX_CTRL, 32'h0000_0004, RESP_OKAY);
	endtask
	task automatic t_reset_values;
		rdc(IDX_REQ_ERR, RST_ERR, RESP_OKAY);
		rdc(IDX_REQ_DET1, RST_DET, RESP_OKAY);
		rdc(IDX_AL1_DET3, RST_DET, RESP_OKAY);
		rdc(IDX_STATUS, 16'h0000, RESP_OKAY);
		rdc(IDX_CTRL, 16'h0004, RESP_OKAY);
	endtask
	// Reset in mid-run, with no bus transfer in flight
	task automatic t_reset_mid;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_values();
	endtask
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		{aresetn, fail_evt, req_err_code, ack_status, req_detail, alarm1_err_code, alarm1_detail} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_values();
		t_detail_stored();
		t_no_detail();
		t_ack_done();
		t_gap_and_map();
		t_reset_mid();
		tally_and_finish();
	end
endmodule
